// ===== logic/nmc_core.sv
// Move, exchange, compare and increment execution slice of a 4-bit core
`timescale 1ns/10ps
`include "nmc_defs.svh"
module nmc_core #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic INSTR_VALID_I,
    input wire logic [7:0] OPCODE_I,
    input wire logic [7:0] OPERAND_I,
    input wire logic [3:0] MEM_RDATA_I,
    output logic INSTR_READY_O,
    output logic DONE_O,
    output logic UNSUPPORTED_O,
    output logic [ADDR_W-1:0] MEM_ADDR_O,
    output logic [3:0] MEM_WDATA_O,
    output logic MEM_WE_O,
    output logic [3:0] WORK_NIBBLE_O,
    output logic [3:0] UPPER_PTR_O,
    output logic [3:0] LOWER_PTR_O,
    output logic [3:0] IRQ_MASK_O,
    output logic CARRY_FLAG_O,
    output logic ZERO_FLAG_O,
    output logic STATUS_FLAG_O
);
    import nmc_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (ADDR_W < 8) begin : g_bad_addr_w
            $error("ADDR_W must cover an 8-bit direct address");
        end
    endgenerate

    // ****************************************
    // Decoding
    // ****************************************
    function automatic nmc_op_type decode_op(input logic [7:0] opc, input logic [7:0] nxt);
        nmc_op_type op;
        op = OP_NONE;
        unique case (opc)
            `NMC_OPC_MOV_H: op = OP_MOV_H;
            `NMC_OPC_MOV_L: op = OP_MOV_L;
            `NMC_OPC_XCH_H: op = OP_XCH_H;
            `NMC_OPC_XCH_L: op = OP_XCH_L;
            `NMC_OPC_XCH_EIR: op = OP_XCH_EIR;
            `NMC_OPC_XCH_IND: op = OP_XCH_IND;
            `NMC_OPC_XCH_DIR: op = OP_XCH_DIR;
            `NMC_OPC_XCH_PAIR: op = OP_XCH_PAIR;
            `NMC_OPC_CMP_IND: op = OP_CMP_IND;
            `NMC_OPC_CMP_DIR: op = OP_CMP_DIR;
            `NMC_OPC_CMP_PG0: op = OP_CMP_PG0;
            `NMC_OPC_ST_PG0: op = OP_ST_PG0;
            `NMC_OPC_INC_A: op = OP_INC_A;
            `NMC_OPC_INC_L: op = OP_INC_L;
            `NMC_OPC_PREFIX: begin
                if (nxt[7:4] == `NMC_HI_PFX_CMP_H) begin
                    op = OP_CMP_H_IMM;
                end else if (nxt[7:4] == `NMC_HI_PFX_CMP_L) begin
                    op = OP_CMP_L_IMM;
                end
            end
            default: begin
                if (opc[7:4] == `NMC_HI_CMP_A) begin
                    op = OP_CMP_A_IMM;
                end
            end
        endcase
        return op;
    endfunction

    function automatic logic [ADDR_W-1:0] widen(input logic [7:0] a);
        return ADDR_W'(a);
    endfunction

    // ****************************************
    // State
    // ****************************************
    nmc_state_type state_r, state_nxt;
    nmc_op_type op_r, op_nxt;
    logic [3:0] ac_r, ac_nxt;
    logic [3:0] hr_r, hr_nxt;
    logic [3:0] lr_r, lr_nxt;
    logic [3:0] eir_r, eir_nxt;
    logic cf_r, cf_nxt;
    logic zf_r, zf_nxt;
    logic sf_r, sf_nxt;
    logic [3:0] imm_r, imm_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [3:0] wdata_r, wdata_nxt;
    logic we_r, we_nxt;
    logic done_r, done_nxt;
    logic unsup_r, unsup_nxt;
    logic ready_r;

    nmc_alu_if alu_bus();
    nmc_alu u_alu (
        .bus(alu_bus)
    );

    // Ready gates the take so that the first edge after reset cannot start an instruction
    wire accept_w = INSTR_VALID_I && ready_r && (state_r == ST_IDLE);
    wire nmc_op_type dec_w = decode_op(OPCODE_I, OPERAND_I);
    wire nmc_op_type cur_op_w = (state_r == ST_IDLE) ? dec_w : op_r;
    wire [7:0] hl_addr_w = {hr_r, lr_r};
    wire [7:0] pair_addr_w = OPERAND_I & `NMC_PAIR_MASK;
    wire [7:0] pg0_addr_w = {`NMC_PAGE_ZERO, OPERAND_I[3:0]};

    // ****************************************
    // ALU operand selection
    // ****************************************
    always_comb begin
        alu_bus.op = ALU_SUB;
        alu_bus.lhs = MEM_RDATA_I;
        alu_bus.rhs = ac_r;
        unique case (cur_op_w)
            OP_CMP_A_IMM: alu_bus.lhs = OPCODE_I[3:0];
            OP_CMP_H_IMM: begin
                alu_bus.lhs = OPERAND_I[3:0];
                alu_bus.rhs = hr_r;
            end
            OP_CMP_L_IMM: begin
                alu_bus.lhs = OPERAND_I[3:0];
                alu_bus.rhs = lr_r;
            end
            OP_CMP_PG0: begin
                alu_bus.lhs = imm_r;
                alu_bus.rhs = MEM_RDATA_I;
            end
            OP_INC_A: begin
                alu_bus.op = ALU_INC;
                alu_bus.lhs = ac_r;
            end
            OP_INC_L: begin
                alu_bus.op = ALU_INC;
                alu_bus.lhs = lr_r;
            end
            default: begin
                alu_bus.lhs = MEM_RDATA_I;
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        ac_nxt = ac_r;
        hr_nxt = hr_r;
        lr_nxt = lr_r;
        eir_nxt = eir_r;
        cf_nxt = cf_r;
        zf_nxt = zf_r;
        sf_nxt = sf_r;
        imm_nxt = imm_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        we_nxt = 1'b0;
        done_nxt = 1'b0;
        unsup_nxt = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (accept_w) begin
                    op_nxt = dec_w;
                    imm_nxt = OPERAND_I[7:4];
                    done_nxt = 1'b1;
                    unique case (dec_w)
                        OP_MOV_H: begin
                            ac_nxt = hr_r;
                            zf_nxt = (hr_r == `NMC_NIB_RST);
                            sf_nxt = `NMC_MOVE_SF;
                        end
                        OP_MOV_L: begin
                            ac_nxt = lr_r;
                            zf_nxt = (lr_r == `NMC_NIB_RST);
                            sf_nxt = `NMC_MOVE_SF;
                        end
                        OP_XCH_H: begin
                            ac_nxt = hr_r;
                            hr_nxt = ac_r;
                            sf_nxt = `NMC_MOVE_SF;
                        end
                        OP_XCH_L: begin
                            ac_nxt = lr_r;
                            lr_nxt = ac_r;
                            sf_nxt = `NMC_MOVE_SF;
                        end
                        OP_XCH_EIR: begin
                            ac_nxt = eir_r;
                            eir_nxt = ac_r;
                            sf_nxt = `NMC_MOVE_SF;
                        end
                        OP_CMP_A_IMM, OP_CMP_H_IMM, OP_CMP_L_IMM: begin
                            zf_nxt = alu_bus.zero;
                            sf_nxt = alu_bus.cout;
                        end
                        OP_INC_A: begin
                            ac_nxt = alu_bus.res;
                            zf_nxt = alu_bus.zero;
                            sf_nxt = alu_bus.cout;
                        end
                        OP_INC_L: begin
                            lr_nxt = alu_bus.res;
                            zf_nxt = alu_bus.zero;
                            sf_nxt = alu_bus.cout;
                        end
                        OP_XCH_IND, OP_CMP_IND: begin
                            addr_nxt = widen(hl_addr_w);
                            done_nxt = 1'b0;
                            state_nxt = ST_RD1;
                        end
                        OP_XCH_DIR, OP_CMP_DIR: begin
                            addr_nxt = widen(OPERAND_I);
                            done_nxt = 1'b0;
                            state_nxt = ST_RD1;
                        end
                        OP_XCH_PAIR: begin
                            addr_nxt = widen(pair_addr_w);
                            done_nxt = 1'b0;
                            state_nxt = ST_RD1;
                        end
                        OP_CMP_PG0: begin
                            addr_nxt = widen(pg0_addr_w);
                            done_nxt = 1'b0;
                            state_nxt = ST_RD1;
                        end
                        OP_ST_PG0: begin
                            addr_nxt = widen(pg0_addr_w);
                            wdata_nxt = OPERAND_I[7:4];
                            we_nxt = 1'b1;
                            done_nxt = 1'b0;
                            state_nxt = ST_WR2;
                        end
                        OP_NONE: begin
                            // Left to other execution units; only flagged here
                            done_nxt = 1'b0;
                            unsup_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_RD1: begin
                // Memory read data is valid one cycle after the address register loads
                unique case (op_r)
                    OP_XCH_IND, OP_XCH_DIR: begin
                        ac_nxt = MEM_RDATA_I;
                        zf_nxt = (MEM_RDATA_I == `NMC_NIB_RST);
                        sf_nxt = `NMC_MOVE_SF;
                        wdata_nxt = ac_r;
                        we_nxt = 1'b1;
                        state_nxt = ST_WR2;
                    end
                    OP_XCH_PAIR: begin
                        lr_nxt = MEM_RDATA_I;
                        wdata_nxt = lr_r;
                        we_nxt = 1'b1;
                        state_nxt = ST_WR1;
                    end
                    default: begin
                        zf_nxt = alu_bus.zero;
                        sf_nxt = alu_bus.cout;
                        done_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                endcase
            end
            ST_WR1: begin
                addr_nxt = addr_r + ADDR_W'(1);
                state_nxt = ST_RD2;
            end
            ST_RD2: begin
                hr_nxt = MEM_RDATA_I;
                sf_nxt = `NMC_MOVE_SF;
                wdata_nxt = hr_r;
                we_nxt = 1'b1;
                state_nxt = ST_WR2;
            end
            ST_WR2: begin
                done_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state_r <= ST_IDLE;
            op_r <= OP_NONE;
            ac_r <= `NMC_NIB_RST;
            hr_r <= `NMC_NIB_RST;
            lr_r <= `NMC_NIB_RST;
            eir_r <= `NMC_NIB_RST;
            imm_r <= `NMC_NIB_RST;
            wdata_r <= `NMC_NIB_RST;
            addr_r <= '0;
            {cf_r, zf_r, sf_r} <= {3{`NMC_FLAG_RST}};
            {we_r, done_r, unsup_r, ready_r} <= 4'h0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            {ac_r, hr_r, lr_r, eir_r} <= {ac_nxt, hr_nxt, lr_nxt, eir_nxt};
            {cf_r, zf_r, sf_r} <= {cf_nxt, zf_nxt, sf_nxt};
            imm_r <= imm_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            {we_r, done_r, unsup_r} <= {we_nxt, done_nxt, unsup_nxt};
            ready_r <= (state_nxt == ST_IDLE);
        end
    end

    assign INSTR_READY_O = ready_r;
    assign DONE_O = done_r;
    assign UNSUPPORTED_O = unsup_r;
    assign MEM_ADDR_O = addr_r;
    assign MEM_WDATA_O = wdata_r;
    assign MEM_WE_O = we_r;
    assign WORK_NIBBLE_O = ac_r;
    assign UPPER_PTR_O = hr_r;
    assign LOWER_PTR_O = lr_r;
    assign IRQ_MASK_O = eir_r;
    // Carry is never changed by this slice; it is kept for the arithmetic units
    assign CARRY_FLAG_O = cf_r;
    assign ZERO_FLAG_O = zf_r;
    assign STATUS_FLAG_O = sf_r;
endmodule

// ===== logic/nmc_defs.svh
// Opcode, field and reset constants for the move/compare execution slice
`ifndef NMC_DEFS_SVH
`define NMC_DEFS_SVH

// ****************************************
// Single-byte and two-byte opcodes
// ****************************************
`define NMC_OPC_MOV_H 8'h10
`define NMC_OPC_MOV_L 8'h11
`define NMC_OPC_XCH_H 8'h30
`define NMC_OPC_XCH_L 8'h31
`define NMC_OPC_XCH_EIR 8'h13
`define NMC_OPC_XCH_IND 8'h0D
`define NMC_OPC_XCH_DIR 8'h3D
`define NMC_OPC_XCH_PAIR 8'h29
`define NMC_OPC_CMP_IND 8'h16
`define NMC_OPC_CMP_DIR 8'h3E
`define NMC_OPC_CMP_PG0 8'h2E
`define NMC_OPC_ST_PG0 8'h2D
`define NMC_OPC_INC_A 8'h08
`define NMC_OPC_INC_L 8'h18
`define NMC_OPC_PREFIX 8'h38

// ****************************************
// Nibble fields and the byte pair address mask
// ****************************************
`define NMC_HI_CMP_A 4'hD
`define NMC_HI_PFX_CMP_H 4'hD
`define NMC_HI_PFX_CMP_L 4'h9
`define NMC_PAGE_ZERO 4'h0
`define NMC_PAIR_MASK 8'hFC

// ****************************************
// Reset values and the status flag value written by moves
// ****************************************
`define NMC_NIB_RST 4'h0
`define NMC_BYTE_RST 8'h00
`define NMC_FLAG_RST 1'b0
`define NMC_MOVE_SF 1'b1

`endif

// ===== logic/nmc_pkg.sv
// Types shared by the move/compare execution slice
package nmc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD1 = 3'b001,
        ST_WR1 = 3'b010,
        ST_RD2 = 3'b011,
        ST_WR2 = 3'b100
    } nmc_state_type;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00000,
        OP_MOV_H = 5'b00001,
        OP_MOV_L = 5'b00010,
        OP_XCH_H = 5'b00011,
        OP_XCH_L = 5'b00100,
        OP_XCH_EIR = 5'b00101,
        OP_XCH_IND = 5'b00110,
        OP_XCH_DIR = 5'b00111,
        OP_XCH_PAIR = 5'b01000,
        OP_CMP_IND = 5'b01001,
        OP_CMP_DIR = 5'b01010,
        OP_CMP_A_IMM = 5'b01011,
        OP_CMP_H_IMM = 5'b01100,
        OP_CMP_L_IMM = 5'b01101,
        OP_CMP_PG0 = 5'b01110,
        OP_INC_A = 5'b01111,
        OP_INC_L = 5'b10000,
        OP_ST_PG0 = 5'b10001
    } nmc_op_type;

    typedef enum logic {
        ALU_SUB = 1'b0,
        ALU_INC = 1'b1
    } nmc_alu_op_type;

endpackage

// ===== logic/nmc_alu_if.sv
// Operand and result bundle between the sequencer and the nibble ALU
`timescale 1ns/10ps
interface nmc_alu_if;
    import nmc_pkg::*;
    logic [3:0] lhs;
    logic [3:0] rhs;
    nmc_alu_op_type op;
    logic [3:0] res;
    logic cout;
    logic zero;

    modport seq (output lhs, output rhs, output op, input res, input cout, input zero);
    modport alu (input lhs, input rhs, input op, output res, output cout, output zero);
endinterface

// ===== logic/nmc_alu.sv
// Nibble ALU: subtract-for-compare and increment
`timescale 1ns/10ps
module nmc_alu (
    nmc_alu_if.alu bus
);
    import nmc_pkg::*;

    wire [4:0] diff_w;
    wire [4:0] incr_w;
    wire [4:0] sel_w;

    // Borrow shows as bit 4 of the difference; carry out as bit 4 of the sum
    assign diff_w = {1'b0, bus.lhs} - {1'b0, bus.rhs};
    assign incr_w = {1'b0, bus.lhs} + 5'h01;
    assign sel_w = (bus.op == ALU_INC) ? incr_w : diff_w;
    assign bus.res = sel_w[3:0];
    assign bus.zero = (sel_w[3:0] == 4'h0);
    // For subtraction cout is "no borrow", so it is high when lhs >= rhs
    assign bus.cout = (bus.op == ALU_INC) ? incr_w[4] : ~diff_w[4];
endmodule

// ===== testbench/nmc_core_chk.sv
// Assertion checker for the move/compare execution slice
`timescale 1ns/10ps
module nmc_core_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic INSTR_VALID_I,
    input wire logic [7:0] OPCODE_I,
    input wire logic [7:0] OPERAND_I,
    input wire logic [3:0] MEM_RDATA_I,
    input wire logic INSTR_READY_O,
    input wire logic DONE_O,
    input wire logic UNSUPPORTED_O,
    input wire logic [ADDR_W-1:0] MEM_ADDR_O,
    input wire logic [3:0] MEM_WDATA_O,
    input wire logic MEM_WE_O,
    input wire logic [3:0] WORK_NIBBLE_O,
    input wire logic [3:0] UPPER_PTR_O,
    input wire logic [3:0] LOWER_PTR_O,
    input wire logic [3:0] IRQ_MASK_O,
    input wire logic CARRY_FLAG_O,
    input wire logic ZERO_FLAG_O,
    input wire logic STATUS_FLAG_O
);
    wire take = INSTR_VALID_I && INSTR_READY_O;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // ****************************************
    // Multi-step memory swap sequences and per-instruction assertions
    // ****************************************
    sequence s_swap_ind;
        ##1 MEM_ADDR_O[7:0] == {$past(UPPER_PTR_O), $past(LOWER_PTR_O)}
        ##1 MEM_WE_O && MEM_WDATA_O == $past(WORK_NIBBLE_O, 2) ##1 DONE_O && INSTR_READY_O;
    endsequence
    sequence s_swap_pair;
        ##1 MEM_ADDR_O[7:0] == ($past(OPERAND_I) & 8'hFC)
        ##1 MEM_WE_O && MEM_WDATA_O == $past(LOWER_PTR_O, 2)
        ##1 !MEM_WE_O && MEM_ADDR_O[7:0] == ($past(OPERAND_I, 3) & 8'hFC) + 8'h01
        ##1 MEM_WE_O && MEM_WDATA_O == $past(UPPER_PTR_O, 4) ##1 DONE_O;
    endsequence

    AST_MOV_H: assert property (take && OPCODE_I == 8'h10 |=> DONE_O
        && WORK_NIBBLE_O == $past(UPPER_PTR_O)
        && ZERO_FLAG_O == ($past(UPPER_PTR_O) == 4'h0) && $stable(CARRY_FLAG_O))
        else $error("move from upper pointer wrong");
    AST_MOV_L: assert property (take && OPCODE_I == 8'h11 |=> DONE_O
        && WORK_NIBBLE_O == $past(LOWER_PTR_O)
        && ZERO_FLAG_O == ($past(LOWER_PTR_O) == 4'h0) && $stable(CARRY_FLAG_O))
        else $error("move from lower pointer wrong");
    AST_XCH_H: assert property (take && OPCODE_I == 8'h30 |=>
        WORK_NIBBLE_O == $past(UPPER_PTR_O) && UPPER_PTR_O == $past(WORK_NIBBLE_O))
        else $error("upper swap wrong");
    AST_XCH_MASK: assert property (take && OPCODE_I == 8'h13 |=> DONE_O
        && IRQ_MASK_O == $past(WORK_NIBBLE_O) && WORK_NIBBLE_O == $past(IRQ_MASK_O))
        else $error("mask swap wrong");
    AST_XCH_IND: assert property (take && OPCODE_I == 8'h0D |-> s_swap_ind)
        else $error("pointer swap sequence wrong");
    AST_XCH_PAIR: assert property (take && OPCODE_I == 8'h29 |-> s_swap_pair)
        else $error("pair swap sequence wrong");
    AST_CMP_IND: assert property (take && OPCODE_I == 8'h16 |=> !MEM_WE_O
        ##1 DONE_O && !MEM_WE_O && $stable(WORK_NIBBLE_O))
        else $error("memory compare wrote");
    AST_CMP_IMM: assert property (take && OPCODE_I[7:4] == 4'hD |=> DONE_O
        && $stable(WORK_NIBBLE_O)
        && ZERO_FLAG_O == ($past(OPCODE_I[3:0]) == $past(WORK_NIBBLE_O))
        && STATUS_FLAG_O == ($past(OPCODE_I[3:0]) >= $past(WORK_NIBBLE_O)))
        else $error("immediate compare wrong");
    AST_INC_A: assert property (take && OPCODE_I == 8'h08 |=>
        WORK_NIBBLE_O == $past(WORK_NIBBLE_O) + 4'h1
        && STATUS_FLAG_O == ($past(WORK_NIBBLE_O) == 4'hF) && $stable(CARRY_FLAG_O))
        else $error("work increment wrong");
    AST_ST_PG0: assert property (take && OPCODE_I == 8'h2D |=> MEM_WE_O
        && MEM_ADDR_O[7:0] == {4'h0, $past(OPERAND_I[3:0])}
        && MEM_WDATA_O == $past(OPERAND_I[7:4]))
        else $error("page zero store wrong");
endmodule

bind nmc_core nmc_core_chk #(.ADDR_W(ADDR_W)) i_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .INSTR_VALID_I(INSTR_VALID_I), .OPCODE_I(OPCODE_I), .OPERAND_I(OPERAND_I),
    .MEM_RDATA_I(MEM_RDATA_I), .INSTR_READY_O(INSTR_READY_O), .DONE_O(DONE_O),
    .UNSUPPORTED_O(UNSUPPORTED_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .MEM_WE_O(MEM_WE_O), .WORK_NIBBLE_O(WORK_NIBBLE_O), .UPPER_PTR_O(UPPER_PTR_O),
    .LOWER_PTR_O(LOWER_PTR_O), .IRQ_MASK_O(IRQ_MASK_O), .CARRY_FLAG_O(CARRY_FLAG_O),
    .ZERO_FLAG_O(ZERO_FLAG_O), .STATUS_FLAG_O(STATUS_FLAG_O));

// ===== testbench/tb.sv
// Self-checking bench for the move/compare execution slice
`timescale 1ns/10ps
module tb;
    import nmc_pkg::*;
    logic clk, nrst, vld, rdy, done, unsup, we, cf, zf, sf;
    logic [7:0] opc, opd, addr;
    logic [3:0] rdata, wdata, acc, hp, lp, msk;
    logic [3:0] mem [0:255];
    int error_cnt = 0;
    int compares = 0;

    // Nibble RAM: combinational read, write on the edge that ends the strobe cycle
    assign rdata = mem[addr];
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    nmc_core #(.ADDR_W(8)) i_dut (.CLK_I(clk), .NRST_I(nrst), .INSTR_VALID_I(vld),
        .OPCODE_I(opc), .OPERAND_I(opd), .MEM_RDATA_I(rdata), .INSTR_READY_O(rdy),
        .DONE_O(done), .UNSUPPORTED_O(unsup), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata),
        .MEM_WE_O(we), .WORK_NIBBLE_O(acc), .UPPER_PTR_O(hp), .LOWER_PTR_O(lp),
        .IRQ_MASK_O(msk), .CARRY_FLAG_O(cf), .ZERO_FLAG_O(zf), .STATUS_FLAG_O(sf));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Drivers and comparison
    // ****************************************
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One edge always passes before valid rises, so valid never toggles twice in a step
    task automatic ex(input logic [7:0] o, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        opc = o;
        opd = d;
        vld = 1'b1;
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        vld = 1'b0;
        while (done !== 1'b1 && unsup !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20) chk("handshake", 4'h0, 4'h1);
    endtask

    task automatic load_a(input logic [3:0] v);
        mem[8'hF0] = v;
        ex(8'h3D, 8'hF0);
    endtask

    task automatic set3(input logic [3:0] a, input logic [3:0] h, input logic [3:0] l);
        load_a(h);
        ex(8'h30, 8'h00);
        load_a(l);
        ex(8'h31, 8'h00);
        load_a(a);
    endtask

    task automatic cmp(input logic [7:0] o, input logic [7:0] d, input logic [3:0] lhs,
                       input logic [3:0] rhs);
        ex(o, d);
        chk("cmp flags", {2'b00, lhs == rhs, lhs >= rhs}, {cf, 1'b0, zf, sf});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_rst;
        chk("regs", 4'h0, acc | hp | lp | msk);
        chk("flags", 4'h0, {1'b0, cf, zf, sf});
        chk("ready", 4'h1, {3'h0, rdy});
    endtask

    task automatic t_mov;
        set3(4'h0, 4'h9, 4'h0);
        ex(8'h10, 8'h00);
        chk("mov_h", 4'h9, acc);
        chk("mov_h flags", 4'h1, {1'b0, cf, zf, sf});
        ex(8'h11, 8'h00);
        chk("mov_l", 4'h0, acc);
        chk("mov_l flags", 4'h3, {1'b0, cf, zf, sf});
    endtask

    task automatic t_xch;
        set3(4'h5, 4'h3, 4'hC);
        ex(8'h30, 8'h00);
        chk("xh acc", 4'h3, acc);
        chk("xh upper", 4'h5, hp);
        ex(8'h31, 8'h00);
        chk("xl acc", 4'hC, acc);
        chk("xl lower", 4'h3, lp);
        ex(8'h13, 8'h00);
        chk("xm acc", 4'h0, acc);
        chk("xm mask", 4'hC, msk);
        ex(8'h13, 8'h00);
        chk("xm back", 4'hC, acc);
    endtask

    task automatic t_xmem;
        set3(4'h6, 4'h2, 4'hA);
        mem[8'h2A] = 4'hC;
        ex(8'h0D, 8'h00);
        chk("xind acc", 4'hC, acc);
        chk("xind mem", 4'h6, mem[8'h2A]);
        chk("xind flags", 4'h1, {1'b0, cf, zf, sf});
        mem[8'h77] = 4'h0;
        ex(8'h3D, 8'h77);
        chk("xdir acc", 4'h0, acc);
        chk("xdir mem", 4'hC, mem[8'h77]);
        chk("xdir zero", 4'h1, {3'h0, zf});
    endtask

    task automatic t_pair;
        set3(4'h0, 4'h8, 4'h3);
        mem[8'h44] = 4'h1;
        mem[8'h45] = 4'hE;
        mem[8'h47] = 4'h5;
        ex(8'h29, 8'h47);
        chk("pair lower", 4'h1, lp);
        chk("pair upper", 4'hE, hp);
        chk("pair m0", 4'h3, mem[8'h44]);
        chk("pair m1", 4'h8, mem[8'h45]);
        chk("pair m3", 4'h5, mem[8'h47]);
    endtask

    task automatic t_cmp;
        load_a(4'h0);
        cmp(8'hD0, 8'h00, 4'h0, 4'h0);
        set3(4'h5, 4'h2, 4'h9);
        mem[8'h29] = 4'h5;
        cmp(8'h16, 8'h00, 4'h5, 4'h5);
        mem[8'h29] = 4'h3;
        cmp(8'h16, 8'h00, 4'h3, 4'h5);
        chk("cmp mem", 4'h3, mem[8'h29]);
        mem[8'hC3] = 4'h7;
        cmp(8'h3E, 8'hC3, 4'h7, 4'h5);
        cmp(8'hD5, 8'h00, 4'h5, 4'h5);
        cmp(8'hD0, 8'h00, 4'h0, 4'h5);
        cmp(8'h38, 8'hD1, 4'h1, 4'h2);
        cmp(8'h38, 8'hD2, 4'h2, 4'h2);
        cmp(8'h38, 8'h99, 4'h9, 4'h9);
        cmp(8'h38, 8'h94, 4'h4, 4'h9);
        mem[8'h03] = 4'h6;
        cmp(8'h2E, 8'h83, 4'h8, 4'h6);
        chk("cmp regs", 4'h5, acc);
        chk("cmp ptrs", 4'h2, hp ^ lp ^ 4'h9);
    endtask

    task automatic t_inc;
        set3(4'hF, 4'h0, 4'hF);
        ex(8'h08, 8'h00);
        chk("inc a", 4'h0, acc);
        chk("inc a flags", 4'h3, {1'b0, cf, zf, sf});
        ex(8'h08, 8'h00);
        chk("inc a2 flags", 4'h0, {1'b0, cf, zf, sf});
        ex(8'h18, 8'h00);
        chk("inc l", 4'h0, lp);
        chk("inc l flags", 4'h3, {1'b0, cf, zf, sf});
    endtask

    task automatic t_st;
        load_a(4'h3);
        mem[8'h07] = 4'h0;
        ex(8'h2D, 8'hB7);
        chk("st mem", 4'hB, mem[8'h07]);
        chk("st flags", 4'h1, {1'b0, cf, zf, sf});
    endtask

    task automatic t_unsup;
        ex(8'hFF, 8'h00);
        chk("unsup", 4'h1, {3'h0, unsup});
        ex(8'h38, 8'h00);
        chk("unsup pfx", 4'h1, {3'h0, unsup});
        chk("unsup acc", 4'h3, acc);
    endtask

    task automatic close_out;
        $display("TB: errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        close_out();
    end

    initial begin
        nrst = 1'b0;
        vld = 1'b0;
        opc = 8'h00;
        opd = 8'h00;
        for (int i = 0; i < 256; i++) mem[i] = 4'h0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_rst();
        t_mov();
        t_xch();
        t_xmem();
        t_pair();
        t_cmp();
        t_inc();
        t_st();
        t_unsup();
        close_out();
    end
endmodule
